// ---- core/pisd_pkg.sv ----
// Constants and types for the PLL input selection and programmable divider.
// Assumes a 32-bit APB slave and one 200 MHz system clock.
// Summary of operation
// - Synthesizer runs only while chip enable is high; otherwise disabled.
// - Divide selected VCO input, compare with reference, drive two error outputs.
// - The VCO pin not selected by the mode is pulled down.
// - Mode 00 off, 01 direct low band, 10 swallow high, 11 swallow low.
// - Mode register bit 3 holds the swallow counter least significant bit.
// - Mode register bit 2 always reads zero.
// - Every reset clears the mode; watchdog reset, chip enable and clock stop keep the flag.
// - Direct mode uses low-band pin, pulls high band down, programmable counter only.
// - Low-band swallow mode uses swallow and programmable counters.
// - Dual-modulus 32/33 prescaler, 5-bit swallow counter, 12-bit programmable counter.
// - Division values load through the data register from the bus buffer.
// - Unlock register bit 0 shows the lock-loss flip-flop.
// - Four-bit reference select field chooses the comparator reference.
// - High-band swallow mode uses high-band pin and pulls low band down.
// - Swallow flag is taken when the data register is written.
package pisd_pkg;
   // Register indices; the byte address is four times the index.
   localparam logic [7:0] IDX_MODE = 8'h10;
   localparam logic [7:0] IDX_REF = 8'h11;
   localparam logic [7:0] IDX_UNLOCK = 8'h12;
   localparam logic [7:0] IDX_STATUS = 8'h13;
   localparam logic [7:0] IDX_MASK = 8'h14;
   localparam logic [7:0] IDX_DATA = 8'h42;
   localparam logic [11:0] ADDR_MODE = {2'h0, IDX_MODE, 2'h0};
   localparam logic [11:0] ADDR_REF = {2'h0, IDX_REF, 2'h0};
   localparam logic [11:0] ADDR_UNLOCK = {2'h0, IDX_UNLOCK, 2'h0};
   localparam logic [11:0] ADDR_STATUS = {2'h0, IDX_STATUS, 2'h0};
   localparam logic [11:0] ADDR_MASK = {2'h0, IDX_MASK, 2'h0};
   localparam logic [11:0] ADDR_DATA = {2'h0, IDX_DATA, 2'h0};
   // Field positions.
   localparam int MODE_ZERO_BIT = 2;
   localparam int MODE_FLAG_BIT = 3;
   localparam int UNLOCK_BIT = 0;
   localparam int ST_LOSS = 0;
   localparam int ST_DIV = 1;
   // Values after reset.
   localparam logic FLAG_RST = 1'b0;
   localparam logic [3:0] REF_RST = 4'h0;
   localparam logic [1:0] MASK_RST = 2'h0;
   localparam logic [16:0] N_RST = 17'h00000;
   // Divider widths and prescaler terminal counts.
   localparam int SWAL_W = 5;
   localparam int PROG_W = 12;
   localparam logic [5:0] PRE_LAST_32 = 6'h1F;
   localparam logic [5:0] PRE_LAST_33 = 6'h20;
   // Division modes.
   typedef enum logic [1:0] {
      MODE_OFF = 2'b00,
      MODE_DIRECT = 2'b01,
      MODE_VHF = 2'b10,
      MODE_HF = 2'b11
   } pisd_mode_e;
endpackage

// ---- core/pisd_divider.sv ----
// Dual-modulus prescaler with swallow and programmable counters.
// Assumes one-cycle input ticks on the system clock.
`timescale 1ns/100ps
`default_nettype none
module pisd_divider (
   // Clock and reset.
   input wire logic clock,
   input wire logic reset,
   // Control.
   input wire logic run,
   input wire logic direct,
   input wire logic load,
   input wire logic tick,
   input wire logic [11:0] prog_value,
   input wire logic [4:0] swallow_value,
   // Divided output.
   output logic div_pulse
);
   logic [5:0] pre_cnt, next_pre_cnt;
   logic [4:0] swal_cnt, next_swal_cnt;
   logic [11:0] prog_cnt, next_prog_cnt;
   logic next_div_pulse;
   logic pre_end;

   ////////////////////////////////////////////////////////////////////////
   // Prescaler runs modulo 33 while swallows remain, else modulo 32.
   always_comb begin
      next_pre_cnt = pre_cnt;
      next_swal_cnt = swal_cnt;
      next_prog_cnt = prog_cnt;
      next_div_pulse = 1'b0;
      pre_end = (swal_cnt != 5'h00) ? (pre_cnt == pisd_pkg::PRE_LAST_33) :
                                      (pre_cnt == pisd_pkg::PRE_LAST_32);
      if (!run || load) begin
         next_pre_cnt = 6'h00;
         next_swal_cnt = swallow_value;
         next_prog_cnt = prog_value;
      end else if (tick && direct) begin
         // Direct mode counts input edges with the programmable counter alone.
         if (prog_cnt <= 12'h001) begin
            next_div_pulse = 1'b1;
            next_prog_cnt = prog_value;
         end else begin
            next_prog_cnt = prog_cnt - 12'h001;
         end
      end else if (tick) begin
         if (pre_end) begin
            next_pre_cnt = 6'h00;
            if (prog_cnt <= 12'h001) begin
               next_div_pulse = 1'b1;
               next_prog_cnt = prog_value;
               next_swal_cnt = swallow_value;
            end else begin
               next_prog_cnt = prog_cnt - 12'h001;
               if (swal_cnt != 5'h00) begin
                  next_swal_cnt = swal_cnt - 5'h01;
               end
            end
         end else begin
            next_pre_cnt = pre_cnt + 6'h01;
         end
      end
   end

   // Counter registers.
   always_ff @(posedge clock) begin
      if (reset) begin
         pre_cnt <= 6'h00;
         swal_cnt <= 5'h00;
         prog_cnt <= 12'h000;
         div_pulse <= 1'b0;
      end else begin
         pre_cnt <= next_pre_cnt;
         swal_cnt <= next_swal_cnt;
         prog_cnt <= next_prog_cnt;
         div_pulse <= next_div_pulse;
      end
   end

   pre_range_a: assert property (@(posedge clock) disable iff (reset)
      pre_cnt <= pisd_pkg::PRE_LAST_33) else $error("Prescaler count out of range.");
   swal_stop_a: assert property (@(posedge clock) disable iff (reset)
      (run && !load && swal_cnt == 5'h00 && !div_pulse) |=> swal_cnt == 5'h00 || $past(tick))
      else $error("Swallow counter moved without a tick.");
endmodule // pisd_divider
`default_nettype wire

// ---- core/pisd_pll_input_select.sv ----
// Input selection, mode registers, divider control and phase comparator.
// Assumes APB master on CLOCK, VCO and chip enable pins asynchronous,
// and a one-cycle reference pulse from the reference divider on CLOCK.
//
// Register access over APB was decided locally.
`timescale 1ns/100ps
`default_nettype none
module pisd_pll_input_select (
   // Clock and resets.
   input wire logic CLOCK,
   input wire logic RESET,
   input wire logic WATCHDOG_STACK_RESET,
   input wire logic CLOCK_STOP,
   // Chip enable pin.
   input wire logic CHIP_ENABLE,
   // APB slave.
   input wire logic PSEL,
   input wire logic PENABLE,
   input wire logic PWRITE,
   input wire logic [11:0] PADDR,
   input wire logic [31:0] PWDATA,
   output logic [31:0] PRDATA,
   output logic PREADY,
   output logic PSLVERR,
   // VCO pins and their pull-downs.
   input wire logic VCO_HIGH_BAND_IN,
   input wire logic VCO_LOW_BAND_IN,
   output logic VCO_HIGH_PULLDOWN,
   output logic VCO_LOW_PULLDOWN,
   // Reference divider.
   input wire logic REF_PULSE,
   output logic [3:0] REF_SELECT,
   // Phase error outputs.
   output logic PHASE_ERR_OUT_A,
   output logic PHASE_ERR_OUT_B,
   output logic PHASE_ERR_OE,
   // Interrupt.
   output logic IRQ
);
   logic ce_meta, ce_sync, vh_meta, vh_sync, vh_prev, vl_meta, vl_sync, vl_prev;
   pisd_pkg::pisd_mode_e div_mode, next_div_mode;
   logic swallow_lsb_flag, next_swallow_lsb_flag;
   logic [3:0] ref_sel, next_ref_sel;
   logic [16:0] n_value, next_n_value;
   logic [1:0] mask, next_mask, status, next_status;
   logic lock_loss_flag, next_lock_loss_flag;
   logic [31:0] next_prdata;
   logic load, next_load;
   logic up, next_up, dn, next_dn;
   logic setup, access, wr, rd, hit_any;
   logic hit_mode, hit_ref, hit_unlock, hit_status, hit_mask, hit_data;
   logic run, direct, tick, div_pulse, loss_evt;

   ////////////////////////////////////////////////////////////////////////
   // Two-flop synchronisers for the asynchronous pins.
   always_ff @(posedge CLOCK) begin
      if (RESET) begin
         ce_meta <= 1'b0;
         ce_sync <= 1'b0;
         vh_meta <= 1'b0;
         vh_sync <= 1'b0;
         vh_prev <= 1'b0;
         vl_meta <= 1'b0;
         vl_sync <= 1'b0;
         vl_prev <= 1'b0;
      end else begin
         ce_meta <= CHIP_ENABLE;
         ce_sync <= ce_meta;
         vh_meta <= VCO_HIGH_BAND_IN;
         vh_sync <= vh_meta;
         vh_prev <= vh_sync;
         vl_meta <= VCO_LOW_BAND_IN;
         vl_sync <= vl_meta;
         vl_prev <= vl_sync;
      end
   end

   ////////////////////////////////////////////////////////////////////////
   // APB decode; the slave answers without wait states.
   assign setup = PSEL && !PENABLE;
   assign access = PSEL && PENABLE;
   assign wr = access && PWRITE;
   assign rd = access && !PWRITE;
   assign hit_mode = PADDR == pisd_pkg::ADDR_MODE;
   assign hit_ref = PADDR == pisd_pkg::ADDR_REF;
   assign hit_unlock = PADDR == pisd_pkg::ADDR_UNLOCK;
   assign hit_status = PADDR == pisd_pkg::ADDR_STATUS;
   assign hit_mask = PADDR == pisd_pkg::ADDR_MASK;
   assign hit_data = PADDR == pisd_pkg::ADDR_DATA;
   assign hit_any = hit_mode | hit_ref | hit_unlock | hit_status | hit_mask | hit_data;
   assign PREADY = 1'b1;
   assign PSLVERR = access && !hit_any;

   // Register file next values, read data captured in the setup cycle.
   always_comb begin
      next_div_mode = div_mode;
      next_swallow_lsb_flag = swallow_lsb_flag;
      next_ref_sel = ref_sel;
      next_n_value = n_value;
      next_mask = mask;
      next_load = 1'b0;
      next_prdata = PRDATA;
      if (wr && hit_mode) begin
         next_div_mode = pisd_pkg::pisd_mode_e'(PWDATA[1:0]);
         next_swallow_lsb_flag = PWDATA[pisd_pkg::MODE_FLAG_BIT];
         next_load = 1'b1;
      end
      if (wr && hit_ref) begin
         next_ref_sel = PWDATA[3:0];
      end
      if (wr && hit_mask) begin
         next_mask = PWDATA[1:0];
      end
      if (wr && hit_data) begin
         next_n_value = {PWDATA[15:0], swallow_lsb_flag};
         next_load = 1'b1;
      end
      if (WATCHDOG_STACK_RESET || CLOCK_STOP || !ce_sync) begin
         next_div_mode = pisd_pkg::MODE_OFF;
      end
      // Read clears the sticky bits, but a new event in that cycle wins.
      next_status = status;
      next_lock_loss_flag = lock_loss_flag;
      if (rd && hit_status) begin
         next_status = 2'h0;
      end
      if (rd && hit_unlock) begin
         next_lock_loss_flag = 1'b0;
      end
      if (loss_evt) begin
         next_status[pisd_pkg::ST_LOSS] = 1'b1;
         next_lock_loss_flag = 1'b1;
      end
      if (div_pulse) begin
         next_status[pisd_pkg::ST_DIV] = 1'b1;
      end
      if (setup) begin
         next_prdata = 32'h00000000;
         unique case (1'b1)
            hit_mode: begin
               next_prdata[pisd_pkg::MODE_FLAG_BIT] = swallow_lsb_flag;
               next_prdata[pisd_pkg::MODE_ZERO_BIT] = 1'b0;
               next_prdata[1:0] = div_mode;
            end
            hit_ref: next_prdata[3:0] = ref_sel;
            hit_unlock: next_prdata[pisd_pkg::UNLOCK_BIT] = lock_loss_flag;
            hit_status: next_prdata[1:0] = status;
            hit_mask: next_prdata[1:0] = mask;
            hit_data: next_prdata[15:0] = n_value[16:1];
            default: next_prdata = 32'h00000000;
         endcase
      end
   end

   // Register file storage.
   always_ff @(posedge CLOCK) begin
      if (RESET) begin
         div_mode <= pisd_pkg::MODE_OFF;
         swallow_lsb_flag <= pisd_pkg::FLAG_RST;
         ref_sel <= pisd_pkg::REF_RST;
         n_value <= pisd_pkg::N_RST;
         mask <= pisd_pkg::MASK_RST;
         status <= 2'h0;
         lock_loss_flag <= 1'b0;
         PRDATA <= 32'h00000000;
         load <= 1'b0;
      end else begin
         div_mode <= next_div_mode;
         swallow_lsb_flag <= next_swallow_lsb_flag;
         ref_sel <= next_ref_sel;
         n_value <= next_n_value;
         mask <= next_mask;
         status <= next_status;
         lock_loss_flag <= next_lock_loss_flag;
         PRDATA <= next_prdata;
         load <= next_load;
      end
   end

   ////////////////////////////////////////////////////////////////////////
   // Input selection: the unused pin is pulled down.
   assign run = ce_sync && (div_mode != pisd_pkg::MODE_OFF);
   assign direct = div_mode == pisd_pkg::MODE_DIRECT;
   assign VCO_HIGH_PULLDOWN = div_mode != pisd_pkg::MODE_VHF;
   assign VCO_LOW_PULLDOWN = (div_mode == pisd_pkg::MODE_VHF) ||
                             (div_mode == pisd_pkg::MODE_OFF);
   assign REF_SELECT = ref_sel;

   // Rising edge of the selected VCO input.
   always_comb begin
      unique case (div_mode)
         pisd_pkg::MODE_VHF: tick = vh_sync && !vh_prev;
         pisd_pkg::MODE_DIRECT, pisd_pkg::MODE_HF: tick = vl_sync && !vl_prev;
         pisd_pkg::MODE_OFF: tick = 1'b0;
      endcase
   end

   // Programmable divider; both counters take the high 12 and low 5 bits.
   pisd_divider u_divider (
      .clock(CLOCK),
      .reset(RESET),
      .run(run),
      .direct(direct),
      .load(load),
      .tick(tick),
      .prog_value(n_value[16:5]),
      .swallow_value(n_value[4:0]),
      .div_pulse(div_pulse)
   );

   ////////////////////////////////////////////////////////////////////////
   // Phase comparator: reference leads raise A, divided leads raise B.
   always_comb begin
      next_up = up || REF_PULSE;
      next_dn = dn || div_pulse;
      loss_evt = run && ((REF_PULSE && up) || (div_pulse && dn));
      if (next_up && next_dn) begin
         next_up = 1'b0;
         next_dn = 1'b0;
      end
      if (!run) begin
         next_up = 1'b0;
         next_dn = 1'b0;
      end
   end

   // Phase comparator state.
   always_ff @(posedge CLOCK) begin
      if (RESET) begin
         up <= 1'b0;
         dn <= 1'b0;
      end else begin
         up <= next_up;
         dn <= next_dn;
      end
   end

   assign PHASE_ERR_OUT_A = up;
   assign PHASE_ERR_OUT_B = dn;
   assign PHASE_ERR_OE = run;
   assign IRQ = |(status & mask);

   ////////////////////////////////////////////////////////////////////////
   // Checks on the behaviour above.
   default clocking cb @(posedge CLOCK); endclocking
   default disable iff (RESET);

   sequence off_two;
      !run ##1 !run;
   endsequence

   ce_off_a: assert property (!ce_sync |=> div_mode == pisd_pkg::MODE_OFF)
      else $error("Mode not cleared while chip enable low.");
   zero_bit_a: assert property ((setup && hit_mode) |=> !PRDATA[pisd_pkg::MODE_ZERO_BIT])
      else $error("Mode bit 2 read as one.");
   flag_write_a: assert property ((wr && hit_mode) |=>
      swallow_lsb_flag == $past(PWDATA[pisd_pkg::MODE_FLAG_BIT]))
      else $error("Swallow flag not stored.");
   flag_keep_a: assert property ((WATCHDOG_STACK_RESET || CLOCK_STOP) && !(wr && hit_mode) |=>
      div_mode == pisd_pkg::MODE_OFF && swallow_lsb_flag == $past(swallow_lsb_flag))
      else $error("Reset handling of mode register wrong.");
   data_flag_a: assert property ((wr && hit_data) |=> n_value[0] == $past(swallow_lsb_flag) &&
      load) else $error("Swallow flag not moved with data write.");
   direct_pins_a: assert property ((div_mode == pisd_pkg::MODE_DIRECT) |->
      VCO_HIGH_PULLDOWN && !VCO_LOW_PULLDOWN) else $error("Direct mode pin choice.");
   vhf_pins_a: assert property ((div_mode == pisd_pkg::MODE_VHF) |->
      !VCO_HIGH_PULLDOWN && VCO_LOW_PULLDOWN && tick == (vh_sync && !vh_prev))
      else $error("High-band swallow pin choice.");
   off_quiet_a: assert property (off_two |-> !div_pulse && !PHASE_ERR_OUT_A)
      else $error("Divider active while disabled.");
   ref_lead_a: assert property ((run && REF_PULSE && !up && !dn && !div_pulse) |=>
      PHASE_ERR_OUT_A && !PHASE_ERR_OUT_B) else $error("Reference lead not shown.");
   div_lead_a: assert property ((run && div_pulse && !up && !dn && !REF_PULSE) |=>
      !PHASE_ERR_OUT_A && PHASE_ERR_OUT_B) else $error("Divided lead not shown.");
   loss_set_a: assert property (loss_evt |=> lock_loss_flag && status[pisd_pkg::ST_LOSS])
      else $error("Lock loss event lost.");
endmodule // pisd_pll_input_select
`default_nettype wire

// ---- verif/pisd_vco_model.sv ----
// Behavioural oscillator standing at the two synthesizer input pins.
// Assumes the core's pull-down outputs; the loop filter is not modelled.
`timescale 1ns/100ps
`default_nettype none
module pisd_vco_model (
   // Control from the bench.
   input wire logic run,
   // Pull-down requests from the core.
   input wire logic high_pulldown,
   input wire logic low_pulldown,
   // Oscillator pins.
   output logic high_pin,
   output logic low_pin
);
   logic osc = 1'h0;

   ////////////////////////////////////////////////////////////////////////////////
   // Free oscillator of 50 ns period, toggling on falling clock edges; it freezes when run is low.
   always begin
      #25;
      if (run) begin
         osc = ~osc;
      end
   end

   // A pin whose pull-down is on reads low whatever the oscillator does.
   assign high_pin = high_pulldown ? 1'h0 : osc;
   assign low_pin = low_pulldown ? 1'h0 : osc;
endmodule // pisd_vco_model
`default_nettype wire

// ---- verif/tb.sv ----
// Self-checking bench for the input selection and divider core.
// Assumes the core package and the oscillator model are compiled first.
`timescale 1ns/100ps
`default_nettype none
module tb;
   typedef struct {logic [3:0] wr; logic [3:0] rd; logic hpd; logic lpd; logic oe;} pisd_row_s;
   logic clock = 1'h0, reset = 1'h1, wdr = 1'h0, cstop = 1'h0, ce = 1'h1, ref_pulse = 1'h0;
   logic psel = 1'h0, penable = 1'h0, pwrite = 1'h0, vco_run = 1'h1, slv;
   logic [11:0] paddr = 12'h000;
   logic [31:0] pwdata = 32'h0, prdata, rd;
   logic pready, pslverr, vhi, vlo, hpd, lpd, err_a, err_b, err_oe, irq;
   logic [3:0] ref_sel;
   int n_errors = 0, samples_checked = 0, edges = 0;
   pisd_row_s rows [5] = '{'{4'h0, 4'h0, 1'h1, 1'h1, 1'h0}, '{4'h5, 4'h1, 1'h1, 1'h0, 1'h1},
      '{4'hA, 4'hA, 1'h0, 1'h1, 1'h1}, '{4'hF, 4'hB, 1'h1, 1'h0, 1'h1},
      '{4'h8, 4'h8, 1'h1, 1'h1, 1'h0}};

   ////////////////////////////////////////////////////////////////////////////////
   // Clock of 5 ns period and a count of oscillator edges on either pin.
   always #2.5 clock = ~clock;
   always @(posedge vhi) edges++;
   always @(posedge vlo) edges++;

   // Core and oscillator model.
   pisd_pll_input_select i_pisd_pll_input_select (.CLOCK(clock), .RESET(reset),
      .WATCHDOG_STACK_RESET(wdr), .CLOCK_STOP(cstop), .CHIP_ENABLE(ce), .PSEL(psel),
      .PENABLE(penable), .PWRITE(pwrite), .PADDR(paddr), .PWDATA(pwdata), .PRDATA(prdata),
      .PREADY(pready), .PSLVERR(pslverr), .VCO_HIGH_BAND_IN(vhi), .VCO_LOW_BAND_IN(vlo),
      .VCO_HIGH_PULLDOWN(hpd), .VCO_LOW_PULLDOWN(lpd), .REF_PULSE(ref_pulse),
      .REF_SELECT(ref_sel), .PHASE_ERR_OUT_A(err_a), .PHASE_ERR_OUT_B(err_b),
      .PHASE_ERR_OE(err_oe), .IRQ(irq));
   pisd_vco_model i_pisd_vco_model (.run(vco_run), .high_pulldown(hpd), .low_pulldown(lpd),
      .high_pin(vhi), .low_pin(vlo));

   ////////////////////////////////////////////////////////////////////////////////
   // Prints the counts and the verdict, then ends the run.
   task automatic wrap_up;
      $display("checks %0d errors %0d", samples_checked, n_errors);
      if (n_errors == 0 && samples_checked > 0) begin
         $display("== PASSED ==");
      end else begin
         $display("== FAILED ==");
      end
      $finish;
   endtask

   // Compares one value and counts it.
   task automatic chk(input logic [32:0] got, input logic [32:0] exp);
      samples_checked++;
      if (got !== exp) begin
         n_errors++;
         $display("BAD %0t got %h expected %h", $time, got, exp);
      end
   endtask

   // One APB transfer; read data and error are taken at the edge that sees pready.
   task automatic apb(input logic w, input logic [11:0] a, input logic [31:0] d);
      int k;
      @(posedge clock);
      psel <= 1'h1;
      pwrite <= w;
      paddr <= a;
      pwdata <= d;
      @(posedge clock);
      penable <= 1'h1;
      for (k = 0; k < 20; k++) begin
         @(posedge clock);
         if (pready === 1'h1) break;
      end
      if (k == 20) begin
         n_errors++;
         wrap_up();
      end
      rd = prdata;
      slv = pslverr;
      psel <= 1'h0;
      penable <= 1'h0;
   endtask

   // Waits, bounded, until the interrupt output is high.
   task automatic wait_irq;
      int k;
      for (k = 0; k < 40000; k++) begin
         @(posedge clock);
         if (irq === 1'h1) break;
      end
      if (k == 40000) begin
         n_errors++;
         wrap_up();
      end
   endtask

   // Programs mode and divisor, then counts oscillator edges between two divided pulses.
   task automatic measure(input logic [3:0] mode, input logic [15:0] dw, input int ratio);
      int s0;
      apb(1'h1, pisd_pkg::ADDR_MODE, {28'h0, mode});
      apb(1'h1, pisd_pkg::ADDR_DATA, {16'h0, dw});
      apb(1'h0, pisd_pkg::ADDR_DATA, 32'h0);
      chk(rd, {16'h0, dw});
      apb(1'h1, pisd_pkg::ADDR_MASK, 32'h2);
      apb(1'h0, pisd_pkg::ADDR_STATUS, 32'h0);
      wait_irq();
      s0 = edges;
      apb(1'h0, pisd_pkg::ADDR_STATUS, 32'h0);
      wait_irq();
      chk(edges - s0, ratio);
      apb(1'h0, pisd_pkg::ADDR_STATUS, 32'h0);
   endtask

   // Sends one reference pulse.
   task automatic pulse_ref;
      @(posedge clock);
      ref_pulse <= 1'h1;
      @(posedge clock);
      ref_pulse <= 1'h0;
      repeat (2) @(posedge clock);
   endtask

   ////////////////////////////////////////////////////////////////////////////////
   // Main sequence: reset, the mode table, then the awkward cases.
   initial begin
      repeat (12) @(posedge clock);
      reset <= 1'h0;
      @(posedge clock);
      #1;
      chk({hpd, lpd, err_oe, irq, ref_sel}, 8'hC0);
      for (int i = 0; i < 5; i++) begin
         apb(1'h1, pisd_pkg::ADDR_MODE, {28'hFFFFFFF, rows[i].wr});
         apb(1'h0, pisd_pkg::ADDR_MODE, 32'h0);
         chk(rd, {28'h0, rows[i].rd});
         chk({hpd, lpd, err_oe}, {rows[i].hpd, rows[i].lpd, rows[i].oe});
      end
      apb(1'h1, pisd_pkg::ADDR_REF, 32'h6);
      // The field is registered at the access edge; look once it has settled.
      #1;
      chk(ref_sel, 4'h6);
      apb(1'h1, 12'h3FC, 32'hFFFFFFFF);
      chk(slv, 1'h1);
      apb(1'h0, 12'h3FC, 32'h0);
      chk({slv, rd}, {1'h1, 32'h0});
      apb(1'h0, pisd_pkg::ADDR_REF, 32'h0);
      chk({slv, rd}, {1'h0, 32'h6});
      apb(1'h1, pisd_pkg::ADDR_MODE, 32'hB);
      ce <= 1'h0;
      repeat (4) @(posedge clock);
      chk({err_oe, hpd, lpd}, 3'h3);
      apb(1'h0, pisd_pkg::ADDR_MODE, 32'h0);
      chk(rd, 32'h8);
      ce <= 1'h1;
      for (int i = 0; i < 2; i++) begin
         apb(1'h1, pisd_pkg::ADDR_MODE, 32'hA);
         wdr <= (i == 0);
         cstop <= (i == 1);
         @(posedge clock);
         wdr <= 1'h0;
         cstop <= 1'h0;
         apb(1'h0, pisd_pkg::ADDR_MODE, 32'h0);
         chk(rd, 32'h8);
      end
      measure(4'h1, 16'h0100, 16);
      measure(4'hB, 16'h0202, 1029);
      measure(4'h2, 16'h0202, 1028);
      apb(1'h1, pisd_pkg::ADDR_MODE, 32'h1);
      apb(1'h1, pisd_pkg::ADDR_MASK, 32'h0);
      rd = 32'h0;
      for (int k = 0; k < 200 && rd[1] !== 1'h1; k++) begin
         chk(irq, 1'h0);
         apb(1'h0, pisd_pkg::ADDR_STATUS, 32'h0);
      end
      chk(rd[1], 1'h1);
      // Stop the oscillator and pass through mode 00 so the comparator starts idle.
      vco_run <= 1'h0;
      apb(1'h1, pisd_pkg::ADDR_MODE, 32'h0);
      apb(1'h1, pisd_pkg::ADDR_MODE, 32'h1);
      apb(1'h1, pisd_pkg::ADDR_MASK, 32'h1);
      apb(1'h0, pisd_pkg::ADDR_STATUS, 32'h0);
      apb(1'h0, pisd_pkg::ADDR_UNLOCK, 32'h0);
      pulse_ref();
      chk({err_a, err_b, err_oe}, 3'h5);
      pulse_ref();
      chk(irq, 1'h1);
      apb(1'h0, pisd_pkg::ADDR_UNLOCK, 32'h0);
      chk(rd, 32'h1);
      apb(1'h0, pisd_pkg::ADDR_UNLOCK, 32'h0);
      chk(rd, 32'h0);
      apb(1'h0, pisd_pkg::ADDR_STATUS, 32'h0);
      chk(rd[0], 1'h1);
      apb(1'h1, pisd_pkg::ADDR_MODE, 32'hF);
      reset <= 1'h1;
      @(posedge clock);
      reset <= 1'h0;
      apb(1'h0, pisd_pkg::ADDR_MODE, 32'h0);
      chk(rd, 32'h0);
      apb(1'h0, pisd_pkg::ADDR_REF, 32'h0);
      chk({rd, irq}, 33'h0);
      wrap_up();
   end
endmodule // tb
`default_nettype wire
